/* rtl/tmb_osc_sync.sv */
`timescale 1ns/1ps
module tmb_osc_sync (
   input  wire logic ref_clk_in,
   input  wire logic rst_n_in,
   input  wire logic osc_pin_in,
   output logic      rise_out
);
   import tmb_pkg::*;

   // ==========================================================
   // Three-stage synchroniser, edge counted when stages 2 and 3 agree
   // ==========================================================
   logic s1;
   logic s2;
   logic s3;
   logic level;

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         s1    <= 1'b0;
         s2    <= 1'b0;
         s3    <= 1'b0;
         level <= 1'b0;
      end else begin
         s1 <= osc_pin_in;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            level <= s3;
         end
      end
   end

   assign rise_out = (s2 == s3) && s3 && !level;
endmodule

/* rtl/tmb_pkg.sv */
package tmb_pkg;

   // ==========================================================
   // Register map (byte addresses, one aligned word each)
   // ==========================================================
   localparam logic [7:0] ADDR_COUNT_LOW     = 8'h00;
   localparam logic [7:0] ADDR_COUNT_HIGH    = 8'h04;
   localparam logic [7:0] ADDR_TIMER_CTRL    = 8'h08;
   localparam logic [7:0] ADDR_NEIGH_CTRL    = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_REQUEST   = 8'h10;
   localparam logic [7:0] ADDR_IRQ_ENABLE    = 8'h14;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int CTRL_WIDE_ACCESS_BIT  = 7;
   localparam int CTRL_PRESCALE_LO_BIT  = 4;
   localparam int CTRL_CLOCK_SOURCE_BIT = 1;
   localparam int CTRL_RUN_BIT          = 0;
   localparam int NEIGH_OSC_ENABLE_BIT  = 3;
   localparam int IRQ_OVERFLOW_BIT      = 1;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [7:0]  CTRL_RESET       = 8'h00;
   localparam logic [7:0]  NEIGH_CTRL_RESET = 8'h00;
   localparam logic [7:0]  IRQ_RESET        = 8'h00;
   localparam logic [15:0] COUNT_RESET      = 16'h0000;
   localparam logic [15:0] COUNT_MAX        = 16'hFFFF;
   localparam logic [2:0]  PRESCALE_RESET   = 3'h0;

   localparam logic [1:0]  RESP_OKAY        = 2'h0;
   localparam logic [1:0]  RESP_SLVERR      = 2'h2;

   // ==========================================================
   // Carried groups
   // ==========================================================
   typedef struct packed {
      logic       wr_low;
      logic       wr_high;
      logic       rd_low;
      logic [7:0] wdata;
   } tmb_access_type;

   typedef struct packed {
      logic       wide_access_enable;
      logic [1:0] prescale_sel;
      logic       clock_source_select;
      logic       run;
   } tmb_ctrl_type;

endpackage

/* rtl/tmb_prescaler.sv */
`timescale 1ns/1ps
module tmb_prescaler (
   input  wire logic       ref_clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       clear_in,
   input  wire logic       tick_in,
   input  wire logic [1:0] sel_in,
   output logic            tick_out
);
   import tmb_pkg::*;

   // ==========================================================
   // Divide by 1, 2, 4 or 8
   // ==========================================================
   logic [2:0] count;
   logic [2:0] limit;

   assign limit    = 3'((4'h1 << sel_in) - 4'h1);
   assign tick_out = tick_in && (count >= limit) && !clear_in;

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         count <= PRESCALE_RESET;
      end else if (clear_in) begin
         count <= PRESCALE_RESET;
      end else if (tick_in) begin
         count <= (count >= limit) ? PRESCALE_RESET : count + 3'h1;
      end
   end
endmodule

/* rtl/tmb_timer.sv */
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module tmb_timer (
   input  wire logic        ref_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        aux_osc_pin_in,
   output logic             aux_osc_run_out,
   output logic             irq_out,
   input  wire logic [7:0]  s_axi_awaddr_in,
   input  wire logic        s_axi_awvalid_in,
   output logic             s_axi_awready_out,
   input  wire logic [31:0] s_axi_wdata_in,
   input  wire logic [3:0]  s_axi_wstrb_in,
   input  wire logic        s_axi_wvalid_in,
   output logic             s_axi_wready_out,
   output logic [1:0]       s_axi_bresp_out,
   output logic             s_axi_bvalid_out,
   input  wire logic        s_axi_bready_in,
   input  wire logic [7:0]  s_axi_araddr_in,
   input  wire logic        s_axi_arvalid_in,
   output logic             s_axi_arready_out,
   output logic [31:0]      s_axi_rdata_out,
   output logic [1:0]       s_axi_rresp_out,
   output logic             s_axi_rvalid_out,
   input  wire logic        s_axi_rready_in
);
   import tmb_pkg::*;

   // ==========================================================
   // State
   // ==========================================================
   logic [15:0]    count;
   logic [7:0]     high_buffer;
   logic [7:0]     timer_control_reg;
   logic [7:0]     neighbour_timer_control_reg;
   logic [7:0]     irq_request_reg_b;
   logic [7:0]     irq_enable_reg_b;
   tmb_ctrl_type   ctrl;
   tmb_access_type acc;

   logic           aw_held;
   logic           w_held;
   logic [7:0]     aw_addr;
   logic [31:0]    w_data;
   logic [3:0]     w_strb;
   logic           do_write;
   logic           do_read;

   logic           osc_rise;
   logic           count_tick;
   logic           scaled_tick;
   logic           overflow;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == ADDR_COUNT_LOW) || (a == ADDR_COUNT_HIGH) ||
               (a == ADDR_TIMER_CTRL) || (a == ADDR_NEIGH_CTRL) ||
               (a == ADDR_IRQ_REQUEST) || (a == ADDR_IRQ_ENABLE);
   endfunction

   assign ctrl.wide_access_enable  = timer_control_reg[CTRL_WIDE_ACCESS_BIT];
   assign ctrl.prescale_sel        = timer_control_reg[CTRL_PRESCALE_LO_BIT +: 2];
   assign ctrl.clock_source_select = timer_control_reg[CTRL_CLOCK_SOURCE_BIT];
   assign ctrl.run                 = timer_control_reg[CTRL_RUN_BIT];

   // ==========================================================
   // AXI4-Lite write channel: address and data taken in either order
   // ==========================================================
   assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
   assign s_axi_wready_out  = !w_held && !s_axi_bvalid_out;
   assign do_write          = aw_held && w_held && !s_axi_bvalid_out;

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         aw_held          <= 1'b0;
         w_held           <= 1'b0;
         aw_addr          <= 8'h00;
         w_data           <= 32'h0000_0000;
         w_strb           <= 4'h0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out  <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_in;
            w_strb <= s_axi_wstrb_in;
         end
         if (do_write) begin
            aw_held          <= 1'b0;
            w_held           <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end
      end
   end

   // Only the low byte lane carries register data; other lanes are ignored.
   assign acc.wr_low  = do_write && w_strb[0] && (aw_addr == ADDR_COUNT_LOW);
   assign acc.wr_high = do_write && w_strb[0] && (aw_addr == ADDR_COUNT_HIGH);
   assign acc.wdata   = w_data[7:0];

   // ==========================================================
   // AXI4-Lite read channel
   // ==========================================================
   assign s_axi_arready_out = !s_axi_rvalid_out;
   assign do_read           = s_axi_arvalid_in && s_axi_arready_out;
   assign acc.rd_low        = do_read && (s_axi_araddr_in == ADDR_COUNT_LOW);

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out  <= 32'h0000_0000;
         s_axi_rresp_out  <= RESP_OKAY;
      end else if (do_read) begin
         s_axi_rvalid_out <= 1'b1;
         s_axi_rresp_out  <= mapped(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr_in)
            ADDR_COUNT_LOW:   s_axi_rdata_out <= {24'h000000, count[7:0]};
            ADDR_COUNT_HIGH: begin
               if (ctrl.wide_access_enable) begin
                  s_axi_rdata_out <= {24'h000000, high_buffer};
               end else begin
                  s_axi_rdata_out <= {24'h000000, count[15:8]};
               end
            end
            ADDR_TIMER_CTRL:  s_axi_rdata_out <= {24'h000000, timer_control_reg};
            ADDR_NEIGH_CTRL:  s_axi_rdata_out <= {24'h000000, neighbour_timer_control_reg};
            ADDR_IRQ_REQUEST: s_axi_rdata_out <= {24'h000000, irq_request_reg_b};
            ADDR_IRQ_ENABLE:  s_axi_rdata_out <= {24'h000000, irq_enable_reg_b};
            default:          s_axi_rdata_out <= 32'h0000_0000;
         endcase
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
         s_axi_rvalid_out <= 1'b0;
      end
   end

   // ==========================================================
   // Control registers
   // ==========================================================
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         timer_control_reg           <= CTRL_RESET;
         neighbour_timer_control_reg <= NEIGH_CTRL_RESET;
         irq_enable_reg_b            <= IRQ_RESET;
      end else if (do_write && w_strb[0]) begin
         case (aw_addr)
            ADDR_TIMER_CTRL: timer_control_reg           <= acc.wdata;
            ADDR_NEIGH_CTRL: neighbour_timer_control_reg <= acc.wdata;
            ADDR_IRQ_ENABLE: irq_enable_reg_b            <= acc.wdata;
            default:         timer_control_reg           <= timer_control_reg;
         endcase
      end
   end

   // ==========================================================
   // Clock source and prescaler
   // ==========================================================
   // The oscillator is gated off when disabled, so its edges cannot count.
   assign aux_osc_run_out =
      neighbour_timer_control_reg[NEIGH_OSC_ENABLE_BIT];

   tmb_osc_sync u_osc_sync (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n_in),
      .osc_pin_in (aux_osc_pin_in),
      .rise_out   (osc_rise)
   );

   always_comb begin
      if (ctrl.clock_source_select) begin
         count_tick = ctrl.run && osc_rise && aux_osc_run_out;
      end else begin
         count_tick = ctrl.run;
      end
   end

   tmb_prescaler u_prescaler (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n_in),
      .clear_in   (acc.wr_low),
      .tick_in    (count_tick),
      .sel_in     (ctrl.prescale_sel),
      .tick_out   (scaled_tick)
   );

   // ==========================================================
   // Counter and high-byte buffer
   // ==========================================================
   assign overflow = scaled_tick && (count == COUNT_MAX) && !acc.wr_low && !acc.wr_high;

   // A software write takes precedence over a coincident count tick.
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         count <= COUNT_RESET;
      end else if (acc.wr_low) begin
         if (ctrl.wide_access_enable) begin
            count <= {high_buffer, acc.wdata};
         end else begin
            count[7:0] <= acc.wdata;
         end
      end else if (acc.wr_high && !ctrl.wide_access_enable) begin
         count[15:8] <= acc.wdata;
      end else if (scaled_tick) begin
         count <= count + 16'h0001;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         high_buffer <= 8'h00;
      end else if (acc.wr_high && ctrl.wide_access_enable) begin
         high_buffer <= acc.wdata;
      end else if (acc.rd_low && ctrl.wide_access_enable) begin
         high_buffer <= count[15:8];
      end
   end

   // ==========================================================
   // Interrupt: sticky flag, write one to clear, set wins
   // ==========================================================
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         irq_request_reg_b <= IRQ_RESET;
      end else begin
         if (do_write && w_strb[0] && (aw_addr == ADDR_IRQ_REQUEST)) begin
            irq_request_reg_b[IRQ_OVERFLOW_BIT] <= irq_request_reg_b[IRQ_OVERFLOW_BIT]
                                                   && !acc.wdata[IRQ_OVERFLOW_BIT];
         end
         if (overflow) begin
            irq_request_reg_b[IRQ_OVERFLOW_BIT] <= 1'b1;
         end
      end
   end

   assign irq_out = |(irq_request_reg_b & irq_enable_reg_b);
endmodule

/* test/tb.sv */
`timescale 1ns/1ps
module tb;
   import tmb_pkg::*;
   logic        clk, rst_n, pin, awv, wv, bry, arv, rry;
   logic        awr, wrd, bv, arr, rv, osc, irq;
   logic [7:0]  awa, ara;
   logic [3:0]  ws;
   logic [31:0] wd, rdat, got;
   logic [1:0]  br, rr, rsp;
   int          mismatches = 0;
   int          checks_done = 0;
   int          seed = 32'h29e6;
   int          k, cnt;

   tmb_timer DUT (
      .ref_clk_in(clk), .rst_n_in(rst_n), .aux_osc_pin_in(pin), .aux_osc_run_out(osc),
      .irq_out(irq), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
      .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd),
      .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bry),
      .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
      .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rry)
   );

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // =========================================================
   // Checking and bus tasks
   // =========================================================
   function automatic logic [31:0] byte_word(input logic [7:0] b);
      return {24'h0, b};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Ready is raised only after valid is seen, so the hold of each answer is exercised.
   // The wait has no limit of its own: a hung answer is caught by the watchdog.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      awa <= a;
      wd <= byte_word(d);
      awv <= 1'b1;
      wv <= 1'b1;
      while (bv !== 1'b1) begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wrd) wv <= 1'b0;
      end
      bry <= 1'b1;
      @(posedge clk);
      rsp = br;
      bry <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      while (rv !== 1'b1) begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
      end
      rry <= 1'b1;
      @(posedge clk);
      got = rdat;
      rsp = rr;
      rry <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      rd(a);
      check(got, byte_word(e));
   endtask

   task automatic pulse(input int num);
      repeat (num) begin
         @(posedge clk);
         pin <= 1'b1;
         repeat (4) @(posedge clk);
         pin <= 1'b0;
         repeat (3) @(posedge clk);
      end
      repeat (8) @(posedge clk);
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      finish_test;
   end

   // =========================================================
   // Scenarios
   // =========================================================
   initial begin
      {rst_n, pin, awv, wv, bry, arv, rry, awa, ara, wd} = '0;
      ws = 4'hF;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 6; i++) rchk(8'(i * 4), 8'h00);
      rd(8'h18);
      check(got, 32'h0);
      check(32'(rsp), 32'(RESP_SLVERR));
      wr(8'h20, 8'hFF);
      check(32'(rsp), 32'(RESP_SLVERR));
      k = $random(seed);
      wr(ADDR_COUNT_HIGH, k[7:0]);
      rchk(ADDR_COUNT_HIGH, k[7:0]);
      wr(ADDR_COUNT_LOW, k[15:8]);
      rchk(ADDR_COUNT_HIGH, k[7:0]);
      wr(ADDR_TIMER_CTRL, 8'h80);
      wr(ADDR_COUNT_HIGH, k[23:16]);
      rchk(ADDR_COUNT_HIGH, k[23:16]);
      wr(ADDR_TIMER_CTRL, 8'h00);
      rchk(ADDR_COUNT_HIGH, k[7:0]);
      wr(ADDR_TIMER_CTRL, 8'h80);
      wr(ADDR_COUNT_HIGH, k[23:16]);
      wr(ADDR_COUNT_LOW, k[31:24]);
      wr(ADDR_TIMER_CTRL, 8'h00);
      rchk(ADDR_COUNT_HIGH, k[23:16]);
      rchk(ADDR_COUNT_LOW, k[31:24]);
      wr(ADDR_TIMER_CTRL, 8'h80);
      wr(ADDR_COUNT_HIGH, ~k[23:16]);
      rchk(ADDR_COUNT_LOW, k[31:24]);
      rchk(ADDR_COUNT_HIGH, k[23:16]);
      wr(ADDR_TIMER_CTRL, 8'h00);
      wr(ADDR_COUNT_HIGH, 8'hFF);
      wr(ADDR_COUNT_LOW, 8'hF0);
      wr(ADDR_TIMER_CTRL, 8'h01);
      repeat (40) @(posedge clk);
      wr(ADDR_TIMER_CTRL, 8'h00);
      rchk(ADDR_COUNT_HIGH, 8'h00);
      rchk(ADDR_IRQ_REQUEST, 8'h02);
      check(32'(irq), 32'h0);
      wr(ADDR_IRQ_ENABLE, 8'h02);
      @(posedge clk);
      check(32'(irq), 32'h1);
      rchk(ADDR_IRQ_REQUEST, 8'h02);
      wr(ADDR_IRQ_ENABLE, 8'h00);
      @(posedge clk);
      check(32'(irq), 32'h0);
      wr(ADDR_IRQ_REQUEST, 8'h02);
      rchk(ADDR_IRQ_REQUEST, 8'h00);
      // A write whose low byte lane is not enabled must leave the register alone.
      ws <= 4'h0;
      wr(ADDR_IRQ_ENABLE, 8'h02);
      ws <= 4'hF;
      rchk(ADDR_IRQ_ENABLE, 8'h00);
      wr(ADDR_NEIGH_CTRL, 8'h08);
      @(posedge clk);
      check(32'(osc), 32'h1);
      wr(ADDR_COUNT_LOW, 8'h00);
      wr(ADDR_COUNT_HIGH, 8'h00);
      wr(ADDR_TIMER_CTRL, 8'h03);
      cnt = 1 + ($random(seed) & 15);
      pulse(cnt);
      wr(ADDR_TIMER_CTRL, 8'h00);
      rchk(ADDR_COUNT_LOW, cnt[7:0]);
      wr(ADDR_NEIGH_CTRL, 8'h00);
      @(posedge clk);
      check(32'(osc), 32'h0);
      wr(ADDR_TIMER_CTRL, 8'h03);
      pulse(3);
      wr(ADDR_TIMER_CTRL, 8'h00);
      rchk(ADDR_COUNT_LOW, cnt[7:0]);
      // Divide by four on the oscillator: only a low write may restart the prescaler.
      wr(ADDR_NEIGH_CTRL, 8'h08);
      wr(ADDR_TIMER_CTRL, 8'h23);
      wr(ADDR_COUNT_LOW, 8'h00);
      pulse(3);
      rchk(ADDR_COUNT_LOW, 8'h00);
      wr(ADDR_COUNT_HIGH, 8'h00);
      pulse(1);
      rchk(ADDR_COUNT_LOW, 8'h01);
      pulse(3);
      wr(ADDR_COUNT_LOW, 8'h00);
      pulse(1);
      rchk(ADDR_COUNT_LOW, 8'h00);
      finish_test;
   end
endmodule

/* test/tmb_timer_assertions.sv */
`timescale 1ns/1ps
module tmb_timer_checker
   import tmb_pkg::*;
(
   input wire logic        ref_clk_in,
   input wire logic        rst_n_in,
   input wire logic        aux_osc_run_out,
   input wire logic        irq_out,
   input wire logic [7:0]  s_axi_awaddr_in,
   input wire logic        s_axi_awvalid_in,
   input wire logic        s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0]  s_axi_wstrb_in,
   input wire logic        s_axi_wvalid_in,
   input wire logic        s_axi_wready_out,
   input wire logic        s_axi_bvalid_out,
   input wire logic        s_axi_bready_in,
   input wire logic        s_axi_arvalid_in,
   input wire logic        s_axi_arready_out,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic        s_axi_rvalid_out,
   input wire logic        s_axi_rready_in
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);

   // =========================================================
   // Write steps
   // =========================================================
   sequence s_wr_taken;
      s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
   endsequence
   sequence s_wr_to(logic [7:0] a);
      s_wr_taken ##0 (s_axi_awaddr_in == a) && s_axi_wstrb_in[0];
   endsequence

   a_reset_quiet: assert property ($rose(rst_n_in) |-> !irq_out && !aux_osc_run_out
      && !s_axi_bvalid_out && !s_axi_rvalid_out) else $error("outputs not idle after reset");
   a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid_out)
      else $error("write response late");
   a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |->
      ##[1:2] s_axi_rvalid_out) else $error("read response late");
   a_bvalid_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
      else $error("write response dropped");
   a_rvalid_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
      s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
   a_busy_refuse: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
      else $error("write accepted while response pending");
   a_read_refuse: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
      else $error("read accepted while data pending");
   a_rdata_narrow: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_osc_follow: assert property (s_wr_to(ADDR_NEIGH_CTRL) |=> ##1
      aux_osc_run_out == $past(s_axi_wdata_in[NEIGH_OSC_ENABLE_BIT], 2))
      else $error("oscillator run does not follow its enable");
   a_irq_masked: assert property (s_wr_to(ADDR_IRQ_ENABLE) ##0
      !s_axi_wdata_in[IRQ_OVERFLOW_BIT] |=> ##1 !irq_out) else $error("masked interrupt raised");
endmodule

bind tmb_timer tmb_timer_checker u_checker (
   .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .aux_osc_run_out(aux_osc_run_out),
   .irq_out(irq_out), .s_axi_awaddr_in(s_axi_awaddr_in), .s_axi_awvalid_in(s_axi_awvalid_in),
   .s_axi_awready_out(s_axi_awready_out), .s_axi_wdata_in(s_axi_wdata_in),
   .s_axi_wstrb_in(s_axi_wstrb_in), .s_axi_wvalid_in(s_axi_wvalid_in),
   .s_axi_wready_out(s_axi_wready_out), .s_axi_bvalid_out(s_axi_bvalid_out),
   .s_axi_bready_in(s_axi_bready_in), .s_axi_arvalid_in(s_axi_arvalid_in),
   .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
   .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in)
);
